// ### spi_register_access_slave.sv
// register slave end: forty-bit datagram link and register bank
//
// Functional notes
// - device is slave; master drives clock, framing
// - fixed forty-bit datagram, up to 2 Mbit/s
// - shift msb first, bit 39 to 0
// - top bit: zero reads, one writes
// - bits 39..32 form the address byte
// - bits 31..0 carry the data payload
// - answer comes inside the same datagram
// - 0x00-0x7F read, 0x80-0xFF write, 128 locations
// - writes to read-only registers are ignored
// - some addresses pack several fields together
// - selector register plus data register: indirect access
// - 0x0100000000 reads 0x01; 0x81... writes 0x01
// - dual-ported count: link writes, hardware updates
// - read-only type, version, date, time identifiers
// - raw pin states mirrored into readable register
`timescale 1ns/1ns
module spi_register_access_slave #(
  parameter logic [31:0] SILICON_TYPE = 32'h0000_1234, // arbitrary value
  parameter logic [31:0] SILICON_VER  = 32'h0001_0000, // arbitrary value
  parameter logic [31:0] SILICON_DATE = 32'h0000_0001, // arbitrary value
  parameter logic [31:0] SILICON_TIME = 32'h0000_0001, // arbitrary value
  parameter int          IND_DEPTH    = 16
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  spi_link_if.device       link,
  input  wire logic [2:0]  hall_i,
  input  wire logic [2:0]  enc_abn_i,
  input  wire logic        enc_step_i,
  output logic      [31:0] ctrl_word_o,
  output logic      [31:0] enc_count_o,
  output logic             wr_commit_o
);

  // ----------------------------------------------------------------
  // link domain: runs on the master's serial clock
  // ----------------------------------------------------------------
  logic [5:0]  bit_cnt;
  logic [38:0] shift_in;
  logic [7:0]  addr_hold;
  logic [31:0] data_hold;
  logic        addr_ready;
  logic        frame_done;
  logic        miso_bit;
  logic        miso_oe_n;
  logic [31:0] rd_data;

  // bit index of the payload bit for the current falling edge
  function automatic logic [4:0] payload_index(input logic [5:0] cnt);
    logic [5:0] idx;
    idx = 6'h27 - cnt;
    return idx[4:0];
  endfunction

  wire in_payload = (bit_cnt >= spi_ra_pkg::CNT_ADDR_DONE) &&
                    (bit_cnt <  spi_ra_pkg::CNT_FRAME_DONE);

  // counter and flags are cleared by the frame's own chip select, since
  // the serial clock stands still between frames
  always_ff @(posedge link.sck or posedge link.chip_select_n) begin
    if (link.chip_select_n) begin
      bit_cnt    <= 6'h00;
      addr_ready <= 1'b0;
      frame_done <= 1'b0;
    end else if (bit_cnt != spi_ra_pkg::CNT_FRAME_DONE) begin
      bit_cnt    <= bit_cnt + 6'h01;
      if (bit_cnt == spi_ra_pkg::CNT_ADDR_DONE - 6'h01)
        addr_ready <= 1'b1;
      if (bit_cnt == spi_ra_pkg::CNT_FRAME_DONE - 6'h01)
        frame_done <= 1'b1;
    end
  end

  // msb-first shift; holds are not cleared so the system side can read them
  // after the frame has already ended
  always_ff @(posedge link.sck) begin
    shift_in <= {shift_in[37:0], link.mosi};
    if (!link.chip_select_n && bit_cnt == spi_ra_pkg::CNT_ADDR_DONE - 6'h01)
      addr_hold <= {shift_in[6:0], link.mosi};
    if (!link.chip_select_n && bit_cnt == spi_ra_pkg::CNT_FRAME_DONE - 6'h01)
      data_hold <= {shift_in[30:0], link.mosi};
  end

  // slave-out changes on falling edges; zeros during the address byte
  always_ff @(negedge link.sck or posedge link.chip_select_n) begin
    if (link.chip_select_n) begin
      miso_bit  <= 1'b0;
      miso_oe_n <= 1'b1;
    end else begin
      miso_oe_n <= 1'b0;
      miso_bit  <= in_payload ? rd_data[payload_index(bit_cnt)] : 1'b0;
    end
  end

  assign link.miso      = miso_bit;
  assign link.miso_oe_n = miso_oe_n;

  // ----------------------------------------------------------------
  // crossing into the system domain
  // ----------------------------------------------------------------
  logic [1:0] flags_sync;
  logic [1:0] flags_prev;
  logic [5:0] raw_sync;

  sync_2ff #(.WIDTH(2)) u_flag_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({frame_done, addr_ready}),
    .sync_o    (flags_sync)
  );

  // raw pins are asynchronous too
  sync_2ff #(.WIDTH(6)) u_raw_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({enc_abn_i, hall_i}),
    .sync_o    (raw_sync)
  );

  // rising edges of the synchronised flags; holds are stable by then
  wire addr_rise = flags_sync[0] & ~flags_prev[0];
  wire done_rise = flags_sync[1] & ~flags_prev[1];

  // ----------------------------------------------------------------
  // register bank (system domain)
  // ----------------------------------------------------------------
  logic [31:0] ind_mem [IND_DEPTH];
  logic [7:0]  ind_sel;
  logic [31:0] ctrl_packed;
  logic [31:0] enc_count;

  wire [6:0] acc_addr  = addr_hold[6:0];
  wire       acc_write = addr_hold[spi_ra_pkg::ADDR_BITS-1];
  wire       ind_hit   = (int'(ind_sel) < IND_DEPTH);
  wire [3:0] ind_idx   = ind_sel[3:0];
  wire [31:0] ind_word = ind_hit ? ind_mem[ind_idx] : 32'h0000_0000;

  // read selection; unmapped reads answer zero
  wire [31:0] rd_word =
    (acc_addr == spi_ra_pkg::REG_SILICON_TYPE) ? SILICON_TYPE :
    (acc_addr == spi_ra_pkg::REG_SILICON_VER)  ? SILICON_VER  :
    (acc_addr == spi_ra_pkg::REG_SILICON_DATE) ? SILICON_DATE :
    (acc_addr == spi_ra_pkg::REG_SILICON_TIME) ? SILICON_TIME :
    (acc_addr == spi_ra_pkg::REG_RAW_INPUTS)   ? {26'h0, raw_sync} :
    (acc_addr == spi_ra_pkg::REG_IND_SELECT)   ? {24'h0, ind_sel} :
    (acc_addr == spi_ra_pkg::REG_IND_DATA)     ? ind_word :
    (acc_addr == spi_ra_pkg::REG_ENC_COUNT)    ? enc_count :
    (acc_addr == spi_ra_pkg::REG_CTRL_PACKED)  ? ctrl_packed :
                                                 32'h0000_0000;

  // a write commits only on a complete frame with the direction bit set
  wire commit   = done_rise & acc_write;
  wire wr_sel   = commit && acc_addr == spi_ra_pkg::REG_IND_SELECT;
  wire wr_ind   = commit && acc_addr == spi_ra_pkg::REG_IND_DATA && ind_hit;
  wire wr_enc   = commit && acc_addr == spi_ra_pkg::REG_ENC_COUNT;
  wire wr_ctrl  = commit && acc_addr == spi_ra_pkg::REG_CTRL_PACKED;

  // edge history and the answer word for the link side
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      flags_prev <= 2'h0;
      rd_data    <= 32'h0000_0000;
    end else begin
      flags_prev <= flags_sync;
      if (addr_rise)
        rd_data <= rd_word;
    end
  end

  // writable registers; read-only ones have no write path at all
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ind_sel     <= spi_ra_pkg::RST_IND_SELECT;
      ctrl_packed <= spi_ra_pkg::RST_CTRL_PACKED;
      wr_commit_o <= 1'b0;
    end else begin
      wr_commit_o <= commit;
      if (wr_sel)
        ind_sel <= data_hold[7:0];
      if (wr_ctrl)
        ctrl_packed <= data_hold;
    end
  end

  // indirect storage holds data only; no reset needed
  always_ff @(posedge clk_sys_i) begin
    if (wr_ind)
      ind_mem[ind_idx] <= data_hold;
  end

  // dual-ported count: a link write wins over a hardware step that cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i)
      enc_count <= spi_ra_pkg::RST_ENC_COUNT;
    else if (wr_enc)
      enc_count <= data_hold;
    else if (enc_step_i)
      enc_count <= enc_count + 32'h0000_0001;
  end

  // ----------------------------------------------------------------
  // user-side outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_word_o <= spi_ra_pkg::RST_CTRL_PACKED;
      enc_count_o <= spi_ra_pkg::RST_ENC_COUNT;
    end else begin
      ctrl_word_o <= ctrl_packed;
      enc_count_o <= enc_count;
    end
  end

endmodule // spi_register_access_slave

// ### spi_ra_pkg.sv
// shared constants for the forty-bit register access link
package spi_ra_pkg;

  // ----------------------------------------------------------------
  // datagram layout
  // ----------------------------------------------------------------
  localparam int DGRAM_BITS = 40;
  localparam int ADDR_BITS  = 8;
  localparam int DATA_BITS  = 32;
  localparam int DIR_POS    = 39;                   // write_not_read_flag
  localparam logic [5:0] CNT_ADDR_DONE  = 6'h08;     // edges after address byte
  localparam logic [5:0] CNT_FRAME_DONE = 6'h28;     // edges after whole frame

  // ----------------------------------------------------------------
  // register offsets (7-bit index within either address space)
  // ----------------------------------------------------------------
  localparam logic [6:0] REG_SILICON_TYPE = 7'h00;
  localparam logic [6:0] REG_SILICON_VER  = 7'h01;
  localparam logic [6:0] REG_SILICON_DATE = 7'h02;
  localparam logic [6:0] REG_SILICON_TIME = 7'h03;
  localparam logic [6:0] REG_RAW_INPUTS   = 7'h04;
  localparam logic [6:0] REG_IND_SELECT   = 7'h05;
  localparam logic [6:0] REG_IND_DATA     = 7'h06;
  localparam logic [6:0] REG_ENC_COUNT    = 7'h07;
  localparam logic [6:0] REG_CTRL_PACKED  = 7'h08;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_CTRL_PACKED = 32'h0000_0000;
  localparam logic [31:0] RST_ENC_COUNT   = 32'h0000_0000;
  localparam logic [7:0]  RST_IND_SELECT  = 8'h00;

  // ----------------------------------------------------------------
  // serial clock timing (host divider)
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCK_HALF_NS   = 250;
  localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ### spi_link_if.sv
// serial link between the application controller and the register slave
`timescale 1ns/1ns
interface spi_link_if;
  logic sck;
  logic chip_select_n;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  logic miso_line;

  // slave-out line idles high while the slave is not driving it
  assign miso_line = miso_oe_n ? 1'b1 : miso;

  modport device (
    input  sck,
    input  chip_select_n,
    input  mosi,
    output miso,
    output miso_oe_n
  );

  modport host (
    output sck,
    output chip_select_n,
    output mosi,
    input  miso_line
  );
endinterface

// ### sync_2ff.sv
// two-stage level synchroniser
`timescale 1ns/1ns
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule // sync_2ff

// ### spi_register_access_master.sv
// application controller end: issues forty-bit datagrams
`timescale 1ns/1ns
module spi_register_access_master #(
  parameter int HALF_CYC = spi_ra_pkg::SCK_HALF_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  spi_link_if.host         link,
  input  wire logic        start_i,
  input  wire logic [39:0] tx_frame_i,
  output logic             busy_o,
  output logic             done_o,
  output logic      [39:0] rx_frame_o
);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LEAD  = 3'b001,
    ST_LOW   = 3'b011,
    ST_HIGH  = 3'b010,
    ST_TRAIL = 3'b110,
    ST_GAP   = 3'b111
  } host_state_t;

  host_state_t state;
  logic [5:0]  timer;
  logic [5:0]  bits;
  logic [39:0] tx_sh;
  logic [39:0] rx_sh;
  logic        miso_s;
  logic        sck;
  logic        cs_n;
  logic        mosi;

  localparam logic [5:0] HALF_LAST = 6'(HALF_CYC - 1);

  sync_2ff #(.WIDTH(1)) u_miso_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   (link.miso_line),
    .sync_o    (miso_s)
  );

  wire expired = (timer == 6'h00);
  wire last    = (bits == spi_ra_pkg::CNT_FRAME_DONE);

  // clock divider and framing; mosi moves on falling, miso taken at rising
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state  <= ST_IDLE;
      timer  <= 6'h00;
      bits   <= 6'h00;
      sck    <= 1'b1;
      cs_n   <= 1'b1;
      mosi   <= 1'b0;
      tx_sh  <= 40'h00_0000_0000;
      rx_sh  <= 40'h00_0000_0000;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      rx_frame_o <= 40'h00_0000_0000;
    end else begin
      done_o <= 1'b0;
      timer  <= expired ? HALF_LAST : timer - 6'h01;
      case (state)
        ST_IDLE: begin
          timer <= HALF_LAST;
          if (start_i) begin
            cs_n   <= 1'b0;
            tx_sh  <= tx_frame_i;
            bits   <= 6'h00;
            busy_o <= 1'b1;
            state  <= ST_LEAD;
          end
        end
        ST_LEAD: if (expired) begin
          sck   <= 1'b0;
          mosi  <= tx_sh[spi_ra_pkg::DIR_POS];
          state <= ST_LOW;
        end
        ST_LOW: if (expired) begin
          sck   <= 1'b1;
          rx_sh <= {rx_sh[38:0], miso_s};
          bits  <= bits + 6'h01;
          state <= ST_HIGH;
        end
        ST_HIGH: if (expired) begin
          if (last) begin
            state <= ST_TRAIL;
          end else begin
            sck   <= 1'b0;
            tx_sh <= {tx_sh[38:0], 1'b0};
            mosi  <= tx_sh[38];
            state <= ST_LOW;
          end
        end
        ST_TRAIL: if (expired) begin
          cs_n       <= 1'b1;
          rx_frame_o <= rx_sh;
          done_o     <= 1'b1;
          state      <= ST_GAP;
        end
        ST_GAP: if (expired) begin
          busy_o <= 1'b0;
          state  <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign link.sck           = sck;
  assign link.chip_select_n = cs_n;
  assign link.mosi          = mosi;

endmodule // spi_register_access_master

// ### spi_link_checker.sv
// concurrent checks on the serial link between the two ends
`timescale 1ns/1ns
module spi_link_checker #(
  parameter int HALF_CYC = 32
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic sck,
  input wire logic chip_select_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n,
  input wire logic miso_line
);
  logic [7:0] hold;
  logic [7:0] gap;
  logic [5:0] rises;
  logic       sck_q;

  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  // counts start saturated so a fresh reset never looks like a short gap
  always_ff @(posedge clk_sys_i) begin
    sck_q <= sck;
    if (!rst_n_i) begin
      hold <= 8'hFF;
      gap  <= 8'hFF;
    end else begin
      hold <= (sck != sck_q) ? 8'h00 : hold + {7'h00, hold != 8'hFF};
      gap  <= !chip_select_n ? 8'h00 : gap + {7'h00, gap != 8'hFF};
    end
  end

  // rising serial clock edges inside the current frame
  always_ff @(posedge clk_sys_i) begin
    if (chip_select_n) begin
      rises <= 6'h00;
    end else if (sck && !sck_q) begin
      rises <= rises + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_cs_drop;
    $fell(chip_select_n);
  endsequence
  sequence s_lead_in;
    sck [*8] ##[1:40] !sck;
  endsequence

  a_frame_lead: assert property (s_cs_drop |-> s_lead_in)
    else $error("serial clock moved too soon after frame start");
  a_forty_rises: assert property (
    $rose(chip_select_n) |-> rises == spi_ra_pkg::CNT_FRAME_DONE)
    else $error("frame did not hold forty clock edges");
  a_half_min: assert property ((sck != sck_q) |-> int'(hold) >= HALF_CYC - 1)
    else $error("serial clock half period too short");
  a_gap_min: assert property (s_cs_drop |-> int'(gap) >= HALF_CYC - 1)
    else $error("chip select high time too short");
  a_idle_released: assert property (
    chip_select_n && $past(chip_select_n) |-> miso_oe_n && miso_line)
    else $error("slave drives the line outside a frame");
  a_idle_sck_high: assert property (chip_select_n |-> sck)
    else $error("serial clock not idle high between frames");
  a_mosi_steady: assert property (
    !chip_select_n && !$past(chip_select_n) && sck && $past(sck) |-> $stable(mosi))
    else $error("master data moved while clock high");
  a_miso_steady: assert property (
    !chip_select_n && !$past(chip_select_n) && sck && $past(sck) |-> $stable(miso))
    else $error("slave data moved while clock high");
  a_addr_zero: assert property (
    !chip_select_n && !miso_oe_n && rises < spi_ra_pkg::CNT_ADDR_DONE |-> !miso)
    else $error("slave data not zero during address byte");
  a_read_drive: assert property (!chip_select_n && rises != 6'h00 |-> !miso_oe_n)
    else $error("slave not driving inside a frame");
endmodule // spi_link_checker

// ### tb_top.sv
// self-checking bench: master and register slave joined over one link
`timescale 1ns/1ns
module tb_top;
  localparam int HALF = 32;
  localparam logic [127:0] IDS = 128'h0000_0D44_0000_0C33_0000_0B22_0000_0A11; // arbitrary ids
  logic        clk_sys_i  = 1'b0;
  logic        rst_n_i    = 1'b0;
  logic        start_i    = 1'b0;
  logic [39:0] tx_frame_i = 40'h00_0000_0000;
  logic [2:0]  hall_i     = 3'h0;
  logic [2:0]  enc_abn_i  = 3'h0;
  logic        enc_step_i = 1'b0;
  logic        busy_o;
  logic        done_o;
  logic        wr_commit_o;
  logic [39:0] rx_frame_o;
  logic [39:0] mosi_seen;
  logic [39:0] miso_seen;
  logic [31:0] ctrl_word_o;
  logic [31:0] enc_count_o;
  logic [31:0] commits    = 32'h0;
  logic [31:0] bits       = 32'h0;
  int          miscompares = 0;
  int          compares    = 0;

  spi_link_if link ();
  spi_register_access_master #(.HALF_CYC(HALF)) u_spi_register_access_master (.clk_sys_i,
    .rst_n_i, .link(link), .start_i, .tx_frame_i, .busy_o, .done_o, .rx_frame_o);
  spi_register_access_slave #(.SILICON_TYPE(IDS[31:0]), .SILICON_VER(IDS[63:32]),
    .SILICON_DATE(IDS[95:64]), .SILICON_TIME(IDS[127:96])) u_spi_register_access_slave (
    .clk_sys_i, .rst_n_i, .link(link), .hall_i, .enc_abn_i, .enc_step_i, .ctrl_word_o,
    .enc_count_o, .wr_commit_o);
  spi_link_checker #(.HALF_CYC(HALF)) u_spi_link_checker (.clk_sys_i, .rst_n_i,
    .sck(link.sck), .chip_select_n(link.chip_select_n), .mosi(link.mosi), .miso(link.miso),
    .miso_oe_n(link.miso_oe_n), .miso_line(link.miso_line));

  // ----------------------------------------------------------------
  // clock and wire monitors
  // ----------------------------------------------------------------
  always #4 clk_sys_i = ~clk_sys_i;

  // shadow both wire directions, first bit lands at the top
  always @(posedge link.sck) begin
    if (!link.chip_select_n) begin
      mosi_seen <= {mosi_seen[38:0], link.mosi};
      miso_seen <= {miso_seen[38:0], link.miso_line};
      bits      <= bits + 32'h1;                     // running total; one driver only
    end
  end
  always @(posedge clk_sys_i) if (wr_commit_o === 1'b1) commits <= commits + 32'h1;

  // ----------------------------------------------------------------
  // compare and helper tasks
  // ----------------------------------------------------------------
  task automatic cmp_frame(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: frame %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask
  function automatic logic [39:0] wr(input logic [6:0] a, input logic [31:0] d);
    return {1'b1, a, d};
  endfunction
  function automatic logic [39:0] rd(input logic [6:0] a);
    return {1'b0, a, 32'h0000_0000};
  endfunction

  // one datagram; chk off where the answer is uninitialised memory
  task automatic xfer(input logic [39:0] f, input logic [39:0] exp, input bit chk);
    int          n;
    logic [31:0] b0;
    b0 = bits;
    cmp_bit(link.miso_line & link.sck, 1'b1);
    start_i    <= 1'b1;
    tx_frame_i <= f;
    @(posedge clk_sys_i);
    start_i <= 1'b0;
    for (n = 0; n < 4000 && done_o !== 1'b1; n++) @(posedge clk_sys_i);
    if (chk) begin
      cmp_frame(rx_frame_o, exp);
      cmp_frame(miso_seen, exp);
    end
    cmp_frame(mosi_seen, f);
    cmp_word(bits - b0, 32'h0000_0028);
    for (n = 0; n < 200 && busy_o !== 1'b0; n++) @(posedge clk_sys_i);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_ident();
    for (int i = 0; i < 4; i++) xfer(rd(7'(i)), {8'h00, IDS[32*i +: 32]}, 1);
  endtask
  task automatic t_ro_unmapped();
    xfer(40'h81_2345_6789, {8'h00, IDS[63:32]}, 1);
    xfer(40'h01_0000_0000, {8'h00, IDS[63:32]}, 1);
    xfer(40'hFF_FFFF_FFFF, 40'h00_0000_0000, 1);
    xfer(40'h7F_0000_0000, 40'h00_0000_0000, 1);
  endtask
  task automatic t_ctrl();
    xfer(wr(7'h08, 32'hDEAD_BEEF), {8'h00, spi_ra_pkg::RST_CTRL_PACKED}, 1);
    cmp_word(ctrl_word_o, 32'hDEAD_BEEF);
    xfer(rd(7'h08), 40'h00_DEAD_BEEF, 1);
  endtask
  task automatic t_raw();
    for (int k = 0; k < 2; k++) begin
      hall_i    <= k ? 3'h2 : 3'h5;
      enc_abn_i <= k ? 3'h5 : 3'h3;
      repeat (4) @(posedge clk_sys_i);
      xfer(rd(7'h04), {34'h0, enc_abn_i, hall_i}, 1);
    end
  endtask
  // selector 15 is the last slot, 16 lies past the end
  task automatic t_indirect();
    xfer(wr(7'h05, 32'h3), {32'h0, spi_ra_pkg::RST_IND_SELECT}, 1);
    xfer(wr(7'h06, 32'h1357_9BDF), 40'h0, 0);
    xfer(wr(7'h05, 32'hF), 40'h03, 1);
    xfer(wr(7'h06, 32'h2468_ACE0), 40'h0, 0);
    xfer(wr(7'h05, 32'h3), 40'h0F, 1);
    xfer(rd(7'h06), 40'h00_1357_9BDF, 1);
    xfer(wr(7'h05, 32'h10), 40'h03, 1);
    xfer(wr(7'h06, 32'hFFFF_FFFF), 40'h0, 1);
    xfer(rd(7'h06), 40'h0, 1);
    xfer(wr(7'h05, 32'hF), 40'h10, 1);
    xfer(rd(7'h06), 40'h00_2468_ACE0, 1);
  endtask
  task automatic t_encoder();
    xfer(wr(7'h07, 32'h64), {8'h00, spi_ra_pkg::RST_ENC_COUNT}, 1);
    repeat (5) begin
      enc_step_i <= 1'b1;
      @(posedge clk_sys_i);
      enc_step_i <= 1'b0;
      @(posedge clk_sys_i);
    end
    repeat (2) @(posedge clk_sys_i);
    cmp_word(enc_count_o, 32'h0000_0069);
    xfer(rd(7'h07), 40'h00_0000_0069, 1);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog sized for about thirty frames of 2657 cycles
  initial begin
    #640000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_ident();
    t_ro_unmapped();
    t_ctrl();
    t_raw();
    t_indirect();
    t_encoder();
    cmp_word(commits, 32'h0000_000C);
    tally_and_finish();
  end
endmodule // tb_top
